//--- design/sib_pkg.sv
// Purpose: constants, register map and types of the status indicator block
// Assumes: 250 MHz mclk, Avalon-MM byte addresses at four times the word index
// Notes: blink tables are in milliseconds, counted from a 1 ms tick
package sib_pkg;

  // clock and timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = (TICK_MS * 1000000000) / CLK_PERIOD_PS;
  localparam int ACT_HOLD_MS = 10;
  // one extra tick so a hold loaded mid-tick still spans the full time
  localparam logic [4:0] ACT_HOLD_LOAD = 5'(ACT_HOLD_MS / TICK_MS + 1);

  // register word indices; byte address is four times the index
  localparam logic [15:0] IDX_COMMON = 16'h40c1;
  localparam logic [15:0] IDX_BLINK_RATE = 16'h40c2;
  localparam logic [15:0] IDX_CONTROL = 16'h40c3;
  localparam logic [15:0] IDX_STATUS = 16'h40c4;

  // reset values
  localparam logic [15:0] RST_COMMON = 16'h0000;
  localparam logic [15:0] RST_BLINK_RATE = 16'hec75;
  localparam logic [15:0] RST_CONTROL = 16'h0310;

  // writable bits
  localparam logic [15:0] MASK_COMMON = 16'h0200;
  localparam logic [15:0] MASK_CONTROL = 16'hfffe;

  // field positions
  localparam int F_REVERSE_DUTY = 9;
  localparam int F_RATE_LSB = 0;
  localparam int F_FORCE_ENABLE = 15;
  localparam int F_FORCE_SEL_LSB = 13;
  localparam int F_ACT_INDEP = 12;
  localparam int F_FDX_ON = 11;
  localparam int F_HDX_ON = 10;
  localparam int F_TX_BLINK = 9;
  localparam int F_RX_BLINK = 8;
  localparam int F_TX_ON = 7;
  localparam int F_RX_ON = 6;
  localparam int F_FAST_ON = 5;
  localparam int F_SLOW_ON = 4;
  localparam int F_COL_BLINK = 3;
  localparam int F_FAST_BLINK = 2;
  localparam int F_SLOW_BLINK = 1;
  localparam int NUM_MODES = 4;

  typedef enum logic [1:0] {
    SIB_FORCE_OFF = 2'b00,
    SIB_FORCE_ON = 2'b01,
    SIB_FORCE_MODE1 = 2'b10,
    SIB_FORCE_MODE2 = 2'b11
  } sib_force_type;

  // link state from the rest of the phy, same clock domain
  typedef struct packed {
    logic link_up;
    logic speed_fast;
    logic full_duplex;
    logic collision;
    logic tx_active;
    logic rx_active;
  } sib_phy_status_type;

  // blink period in ms for a rate code
  function automatic logic [13:0] sib_period_ms(input logic [3:0] code);
    case (code)
      4'h0: sib_period_ms = 14'd10000;
      4'h1: sib_period_ms = 14'd9400;
      4'h2: sib_period_ms = 14'd8000;
      4'h3: sib_period_ms = 14'd7400;
      4'h4: sib_period_ms = 14'd6000;
      4'h5: sib_period_ms = 14'd4000;
      4'h6: sib_period_ms = 14'd4000;
      4'h7: sib_period_ms = 14'd3000;
      4'h8: sib_period_ms = 14'd2000;
      4'h9: sib_period_ms = 14'd1000;
      4'ha: sib_period_ms = 14'd500;
      4'hb: sib_period_ms = 14'd333;
      4'hc: sib_period_ms = 14'd250;
      4'hd: sib_period_ms = 14'd166;
      4'he: sib_period_ms = 14'd125;
      default: sib_period_ms = 14'd100;
    endcase
  endfunction : sib_period_ms

  // off time in ms at default duty polarity
  function automatic logic [13:0] sib_off_ms(input logic [3:0] code);
    case (code)
      4'h0: sib_off_ms = 14'd600;
      4'h1: sib_off_ms = 14'd658;
      4'h2: sib_off_ms = 14'd640;
      4'h3: sib_off_ms = 14'd666;
      4'h4: sib_off_ms = 14'd660;
      4'h5: sib_off_ms = 14'd320;
      4'h6: sib_off_ms = 14'd320;
      4'h7: sib_off_ms = 14'd330;
      4'h8: sib_off_ms = 14'd320;
      4'h9: sib_off_ms = 14'd160;
      4'ha: sib_off_ms = 14'd250;
      4'hb: sib_off_ms = 14'd166;
      4'hc: sib_off_ms = 14'd125;
      4'hd: sib_off_ms = 14'd83;
      4'he: sib_off_ms = 14'd62;
      default: sib_off_ms = 14'd50;
    endcase
  endfunction : sib_off_ms

endpackage : sib_pkg

//--- design/sib_blink_gen.sv
// Purpose: one blink-rate generator, lit/dark phase for a 4-bit rate code
// Assumes: tick_ms is a one-cycle pulse every millisecond
// Notes: on phase comes first in each period
`timescale 1ns/1ps
module sib_blink_gen
  import sib_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // timing and setup
  input wire logic tick_ms,
  input wire logic [3:0] rate_code,
  input wire logic reverse_duty,
  // phase
  output logic phase_on
);

  logic [13:0] ms_cnt_r;
  logic [13:0] ms_cnt_nxt;
  logic phase_nxt;
  wire logic [13:0] period = sib_period_ms(rate_code);
  wire logic [13:0] off_time = sib_off_ms(rate_code);
  wire logic [13:0] on_time = reverse_duty ? off_time : period - off_time;
  // >= also recovers a count left high by a shorter newly written code
  wire logic wrap = ms_cnt_r >= period - 14'd1;

  assign ms_cnt_nxt = !tick_ms ? ms_cnt_r : (wrap ? 14'd0 : ms_cnt_r + 14'd1);
  assign phase_nxt = ms_cnt_nxt < on_time;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r <= 14'd0;
      phase_on <= 1'b0;
    end else begin
      ms_cnt_r <= ms_cnt_nxt;
      phase_on <= phase_nxt;
    end
  end

endmodule : sib_blink_gen

//--- design/sib_indicator.sv
// Purpose: second status indicator control with blink-rate selection
// Assumes: phy status inputs on mclk; Avalon-MM slave, byte addresses
// Notes: every access takes one wait cycle; unmapped reads return zero
`timescale 1ns/1ps
module sib_indicator
  import sib_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register bus
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // phy status
  input wire sib_phy_status_type phy_status,
  // indicator pin
  output logic indicator_on
);

  // the tick divider counter is only 20 bits wide
  if (TICK_LEN < 2 || TICK_LEN > 1000000) begin : g_bad_tick
    $error("sib_indicator: TICK_LEN out of range");
  end

  // register state
  logic [15:0] common_r;
  logic [15:0] blink_rate_r;
  logic [15:0] control_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [19:0] tick_cnt_r;
  logic tick_r;
  logic [4:0] tx_hold_r;
  logic [4:0] rx_hold_r;
  logic indicator_nxt;
  logic [NUM_MODES-1:0] mode_phase;

  // bus decode
  wire logic [15:0] word_idx = avs_address[17:2];
  wire logic req = avs_read | avs_write;
  wire logic take = req & ack_r;
  wire logic [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic wr_common = take & avs_write & (word_idx == IDX_COMMON);
  wire logic wr_rate = take & avs_write & (word_idx == IDX_BLINK_RATE);
  wire logic wr_control = take & avs_write & (word_idx == IDX_CONTROL);

  // one wait cycle keeps the read mux off the address path
  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata = rdata_r;

  function automatic logic [15:0] merge(input logic [15:0] old_val,
                                        input logic [15:0] mask);
    merge = (old_val & ~mask) | (avs_writedata[15:0] & mask);
  endfunction : merge

  // field views
  wire logic reverse_duty = common_r[F_REVERSE_DUTY];
  wire logic force_enable = control_r[F_FORCE_ENABLE];
  wire sib_force_type force_select = sib_force_type'(control_r[F_FORCE_SEL_LSB +: 2]);
  wire logic activity_blink_independent = control_r[F_ACT_INDEP];
  wire logic full_duplex_on_enable = control_r[F_FDX_ON];
  wire logic half_duplex_on_enable = control_r[F_HDX_ON];
  wire logic transmit_blink_enable = control_r[F_TX_BLINK];
  wire logic receive_blink_enable = control_r[F_RX_BLINK];
  wire logic transmit_on_enable = control_r[F_TX_ON];
  wire logic receive_on_enable = control_r[F_RX_ON];
  wire logic fast_speed_on_enable = control_r[F_FAST_ON];
  wire logic slow_speed_on_enable = control_r[F_SLOW_ON];
  wire logic collision_blink_enable = control_r[F_COL_BLINK];
  wire logic fast_speed_blink_enable = control_r[F_FAST_BLINK];
  wire logic slow_speed_blink_enable = control_r[F_SLOW_BLINK];

  // status views
  wire logic link = phy_status.link_up;
  wire logic fast = phy_status.speed_fast;
  wire logic fdx = phy_status.full_duplex;
  wire logic tx_seen = phy_status.tx_active | (tx_hold_r != 5'd0);
  wire logic rx_seen = phy_status.rx_active | (rx_hold_r != 5'd0);

  // read data
  wire logic [15:0] status_word = {9'h000, rx_seen, tx_seen, mode_phase, indicator_on};
  wire logic [15:0] rd_word =
    (word_idx == IDX_COMMON) ? common_r :
    (word_idx == IDX_BLINK_RATE) ? blink_rate_r :
    (word_idx == IDX_CONTROL) ? control_r :
    (word_idx == IDX_STATUS) ? status_word : 16'h0000;

  // registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      common_r <= RST_COMMON;
      blink_rate_r <= RST_BLINK_RATE;
      control_r <= RST_CONTROL;
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r & avs_read) begin
        rdata_r <= {16'h0000, rd_word};
      end
      if (wr_common) begin
        common_r <= merge(common_r, be_mask & MASK_COMMON);
      end
      if (wr_rate) begin
        blink_rate_r <= merge(blink_rate_r, be_mask);
      end
      if (wr_control) begin
        control_r <= merge(control_r, be_mask & MASK_CONTROL);
      end
    end
  end

  // millisecond tick divider
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 20'h00000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_cnt_r == 20'(TICK_LEN - 1);
      tick_cnt_r <= (tick_cnt_r == 20'(TICK_LEN - 1)) ? 20'h00000 : tick_cnt_r + 20'h00001;
    end
  end

  // activity stretch: reload while active, count down on ticks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold_r <= 5'd0;
      rx_hold_r <= 5'd0;
    end else begin
      if (phy_status.tx_active) begin
        tx_hold_r <= ACT_HOLD_LOAD;
      end else if (tick_r && tx_hold_r != 5'd0) begin
        tx_hold_r <= tx_hold_r - 5'd1;
      end
      if (phy_status.rx_active) begin
        rx_hold_r <= ACT_HOLD_LOAD;
      end else if (tick_r && rx_hold_r != 5'd0) begin
        rx_hold_r <= rx_hold_r - 5'd1;
      end
    end
  end

  // one generator per blink mode, code nibbles high mode 0 to low mode 3
  for (genvar m = 0; m < NUM_MODES; m++) begin : g_mode
    sib_blink_gen u_gen (
      .mclk(mclk),
      .rst_n(rst_n),
      .tick_ms(tick_r),
      .rate_code(blink_rate_r[F_RATE_LSB + 4 * (NUM_MODES - 1 - m) +: 4]),
      .reverse_duty(reverse_duty),
      .phase_on(mode_phase[m])
    );
  end

  // steady-on terms
  wire logic on_duplex = link & ((full_duplex_on_enable & fdx)
                               | (half_duplex_on_enable & ~fdx));
  wire logic on_speed = link & ((fast_speed_on_enable & fast)
                              | (slow_speed_on_enable & ~fast));
  wire logic on_traffic = link & ((transmit_on_enable & tx_seen)
                                | (receive_on_enable & rx_seen));
  wire logic steady_on = on_duplex | on_speed | on_traffic;

  // activity blinks only when independent or a speed/duplex lamp is lit
  wire logic act_qualify = activity_blink_independent | on_duplex | on_speed;
  wire logic blink_traffic = link & act_qualify
                           & ((transmit_blink_enable & tx_seen)
                            | (receive_blink_enable & rx_seen));
  wire logic blink_other = link & ((collision_blink_enable & phy_status.collision)
                                 | (fast_speed_blink_enable & fast)
                                 | (slow_speed_blink_enable & ~fast));
  wire logic blink_active = blink_traffic | blink_other;

  // output selection
  always_comb begin
    indicator_nxt = 1'b0;
    if (force_enable) begin
      case (force_select)
        SIB_FORCE_OFF: indicator_nxt = 1'b0;
        SIB_FORCE_ON: indicator_nxt = 1'b1;
        SIB_FORCE_MODE1: indicator_nxt = mode_phase[1];
        SIB_FORCE_MODE2: indicator_nxt = mode_phase[2];
        default: indicator_nxt = 1'b0;
      endcase
    end else if (blink_active) begin
      indicator_nxt = mode_phase[2];
    end else begin
      indicator_nxt = steady_on;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      indicator_on <= 1'b0;
    end else begin
      indicator_on <= indicator_nxt;
    end
  end

endmodule : sib_indicator

//--- bench/sib_led_model.sv
// Purpose: status lamp hanging on the indicator pin
// Assumes: pin active high, seen on mclk
// Notes: counts lamp changes so that blink rates can be judged
`timescale 1ns/1ps
module sib_led_model
(
  // clock
  input wire logic mclk,
  // pin and control
  input wire logic indicator_on,
  input wire logic clear,
  // observation
  output logic lit_r,
  output int toggles_r
);
  always_ff @(posedge mclk) begin
    lit_r <= indicator_on;
    if (clear) toggles_r <= 0;
    else if (indicator_on != lit_r) toggles_r <= toggles_r + 1;
  end
endmodule : sib_led_model

//--- bench/sib_indicator_asserts.sv
// Purpose: port checks for sib_indicator
// Assumes: control register shadowed from accepted bus writes
// Notes: the lamp lags its causes by one edge, hence the two-cycle antecedents
`timescale 1ns/1ps
module sib_indicator_asserts
  import sib_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register bus
  input wire logic [17:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // status and pin
  input wire sib_phy_status_type phy_status,
  input wire logic indicator_on
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [15:0] ctl_r;
  logic [15:0] ctl_nxt;
  wire ctl_hit = avs_write && !avs_waitrequest && avs_address[17:2] == IDX_CONTROL;
  wire up = phy_status.link_up;
  wire fast = phy_status.speed_fast;
  wire full = phy_status.full_duplex;
  // bit 0 never stores
  assign ctl_nxt[7:0] = (ctl_hit && avs_byteenable[0]) ? {avs_writedata[7:1], 1'b0} : ctl_r[7:0];
  assign ctl_nxt[15:8] = (ctl_hit && avs_byteenable[1]) ? avs_writedata[15:8] : ctl_r[15:8];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) ctl_r <= RST_CONTROL;
    else ctl_r <= ctl_nxt;
  end
  a_force_off: assert property ((ctl_r[15:13] == 3'b100) [*2] |-> !indicator_on)
    else $error("forced off but lit");
  a_force_on: assert property ((ctl_r[15:13] == 3'b101) [*2] |-> indicator_on)
    else $error("forced on but dark");
  a_idle_dark: assert property ((ctl_r[15:1] == 15'h0) [*2] |-> !indicator_on)
    else $error("lit with nothing enabled");
  a_slow_steady: assert property ((ctl_r == 16'h0010 && up && !fast) [*2] |-> indicator_on)
    else $error("slow link not lit");
  a_fast_steady: assert property ((ctl_r == 16'h0020 && up && fast) [*2] |-> indicator_on)
    else $error("fast link not lit");
  a_full_lit: assert property ((ctl_r == 16'h0800 && up && full) [*2] |-> indicator_on)
    else $error("full duplex not lit");
  a_half_lit: assert property ((ctl_r == 16'h0400 && up && !full) [*2] |-> indicator_on)
    else $error("half duplex not lit");
  a_half_dark: assert property ((ctl_r == 16'h0400 && full) [*2] |-> !indicator_on)
    else $error("half duplex enable lit on full duplex");
  a_down_dark: assert property ((!ctl_r[15] && ctl_r[9:6] == 4'h0 && !up) [*2] |-> !indicator_on)
    else $error("lit with link down");
  c_forced: cover property (ctl_r[15] && indicator_on);
  c_blink: cover property (ctl_r == 16'h0004 && $fell(indicator_on));
  c_write: cover property (ctl_hit);
endmodule : sib_indicator_asserts

bind sib_indicator sib_indicator_asserts sib_indicator_asserts_i (.mclk, .rst_n, .avs_address,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .phy_status, .indicator_on);

//--- bench/testbench.sv
// Purpose: self-checking bench for sib_indicator
// Assumes: TICK_LEN of 10 cycles stands for one millisecond
// Notes: read data, lamp level and blink counts are judged by monitors
`timescale 1ns/1ps
module testbench
  import sib_pkg::*;
;
  localparam int TL = 10;
  localparam logic [15:0] ST_CTL [11] = '{16'h0010, 16'h0010, 16'h0020, 16'h0800, 16'h0400,
    16'h0400, 16'h8010, 16'ha000, 16'h0000, 16'h0010, 16'h0200};
  localparam logic [5:0] ST_STS [11] = '{6'h20, 6'h30, 6'h30, 6'h28, 6'h28, 6'h20, 6'h20,
    6'h00, 6'h3f, 6'h00, 6'h22};
  localparam logic [10:0] ST_EXP = 11'b10110101000;
  localparam logic [15:0] BL_CTL [8] = '{16'h0004, 16'h0002, 16'h0008, 16'h1200, 16'h1100,
    16'h0210, 16'hc000, 16'he000};
  localparam logic [5:0] BL_STS [8] = '{6'h30, 6'h20, 6'h34, 6'h22, 6'h21, 6'h22, 6'h00, 6'h00};
  // mode 1 runs code c (1250-cycle halves), mode 2 code f (500-cycle halves)
  localparam int BL_TOG [8] = '{4, 4, 4, 4, 4, 4, 2, 4};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [17:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  sib_phy_status_type phy_status = '0;
  logic indicator_on;
  logic clear = 1'b1;
  logic lit;
  int toggles;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int tol_e;
  logic [31:0] rd_q[$];
  logic lamp_q[$];
  int tog_q[$];
  event probe;
  event tprobe;
  logic [15:0] rnd;

  always #2 mclk = ~mclk;

  sib_indicator #(.TICK_LEN(TL)) sib_indicator_i (.mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .phy_status(phy_status), .indicator_on(indicator_on));
  sib_led_model sib_led_model_i (.mclk(mclk), .indicator_on(indicator_on), .clear(clear),
    .lit_r(lit), .toggles_r(toggles));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  always @(posedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) cmp(avs_readdata, rd_q.pop_front());
  end
  always @(probe) cmp({31'h0, lit}, {31'h0, lamp_q.pop_front()});
  // blink alignment is free running, so one change either way is allowed
  always @(tprobe) begin
    tol_e = tog_q.pop_front();
    cmp({31'h0, toggles >= tol_e - 1 && toggles <= tol_e + 1}, 32'h1);
  end

  task automatic tally_and_finish();
    $display("comparisons=%0d errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] d);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {16'h0, d};
    avs_byteenable <= 4'h3;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, idx, 16'h0);
  endtask : rd

  task automatic setup(input logic [15:0] ctl, input logic [5:0] st, input int n);
    bus(1'b1, IDX_CONTROL, ctl);
    phy_status <= sib_phy_status_type'(st);
    repeat (n) @(posedge mclk);
  endtask : setup

  initial begin
    rnd = 16'($urandom(32'h05f34397));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(IDX_BLINK_RATE, 32'h0000ec75);
    rd(IDX_CONTROL, 32'h00000310);
    bus(1'b1, IDX_CONTROL, 16'hffff);
    rd(IDX_CONTROL, 32'h0000fffe);
    bus(1'b1, IDX_COMMON, 16'hffff);
    rd(IDX_COMMON, 32'h00000200);
    rnd = 16'($urandom());
    bus(1'b1, IDX_BLINK_RATE, rnd);
    rd(IDX_BLINK_RATE, {16'h0, rnd});
    rd(16'h0123, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 11; i++) begin
      setup(ST_CTL[i], ST_STS[i], 4);
      lamp_q.push_back(ST_EXP[10 - i]);
      -> probe;
    end
    $display("test steady done");
    bus(1'b1, IDX_BLINK_RATE, 16'hccf5);
    for (int i = 0; i < 8; i++) begin
      setup(BL_CTL[i], BL_STS[i], 1);
      clear <= 1'b0;
      repeat (2000) @(posedge mclk);
      tog_q.push_back(BL_TOG[i]);
      -> tprobe;
      clear <= 1'b1;
    end
    $display("test blink done");
    for (int i = 0; i < 2; i++) begin
      setup(16'h0080 >> i, 6'h20, 4);
      phy_status <= sib_phy_status_type'(6'h20 | (6'h02 >> i));
      @(posedge mclk);
      phy_status <= sib_phy_status_type'(6'h20);
      repeat (9 * TL) @(posedge mclk);
      lamp_q.push_back(1'b1);
      -> probe;
      repeat (4 * TL) @(posedge mclk);
      lamp_q.push_back(1'b0);
      -> probe;
    end
    $display("test stretch done");
    bus(1'b1, IDX_CONTROL, 16'ha000);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(IDX_CONTROL, 32'h00000310);
    rd(IDX_BLINK_RATE, 32'h0000ec75);
    rd(IDX_STATUS, 32'h0000001f);
    $display("test reset done");
    @(posedge mclk);
    tally_and_finish();
  end
endmodule : testbench
